// file: inc/pmr_pkg.sv
// Function
// - Hold reset while supply is low; after it rises, run a 128 ms release timer.
// - Keep reset released on falling supply until it drops below 1 V.
// - Idle request bit 0 enters idle; sleep request bit 1 enters power-down.
// - Idle keeps oscillator and peripheral clocks running, stops the core clock.
// - Idle preserves core registers; port pins and DAC outputs keep their states.
// - Idle drives address latch strobe and program store strobe high.
// - Idle ends on any enabled interrupt or hardware reset.
// - Power-down stops PLL and core clock; oscillator stops only if off-in-sleep set.
// - Power-down shuts all peripherals except the interval wake timer.
// - Power-down keeps port levels, floats DAC, drives both strobes low.
// - External reset in power-down returns to normal with registers at defaults.
// - With oscillator running, an enabled interval timer interrupt wakes the device.
// - Serial wake enable lets an enabled serial interrupt wake from power-down.
// - External interrupt zero wake enable lets that interrupt wake from power-down.
// - Wake by interrupt resumes after the instruction that requested power-down.
// - After wake, code runs while the PLL relocks for about 1 ms.
// - PLL lock status flag sits at bit 6 of the PLL control register.
// - A stopped oscillator needs about 150 ms startup before PLL lock begins.
`default_nettype none

package pmr_pkg;

    // Clock rate of the block in hertz.
    localparam int unsigned CLK_HZ = 10_000_000;

    // Timing figures as printed, and derived cycle counts.
    localparam int unsigned POR_RELEASE_MS = 128;
    localparam int unsigned PLL_LOCK_US = 1000;
    localparam int unsigned OSC_START_MS = 150;
    localparam int unsigned POR_CYCLES = POR_RELEASE_MS * (CLK_HZ / 1000);
    localparam int unsigned LOCK_CYCLES = PLL_LOCK_US * (CLK_HZ / 1_000_000);
    localparam int unsigned OSC_CYCLES = OSC_START_MS * (CLK_HZ / 1000);

    // Register byte addresses.
    localparam logic [7:0] PWR_CTRL_ADDR = 8'h00;
    localparam logic [7:0] PLL_CTRL_ADDR = 8'h04;
    localparam logic [7:0] MODE_STAT_ADDR = 8'h08;

    // Field positions in the power control register.
    localparam int unsigned IDLE_BIT = 0;
    localparam int unsigned SLEEP_BIT = 1;
    localparam int unsigned SER_WAKE_BIT = 2;
    localparam int unsigned EXT0_WAKE_BIT = 3;
    localparam int unsigned TIMER_EN_BIT = 4;

    // Field positions in the PLL control register.
    localparam int unsigned OSC_OFF_BIT = 3;
    localparam int unsigned LOCK_BIT = 6;

    // Reset values.
    localparam logic [7:0] PWR_CTRL_RST = 8'h00;
    localparam logic [7:0] PLL_CTRL_RST = 8'h00;

    // Operating modes.
    typedef enum logic [2:0] {
        PMR_RESET = 3'b000,
        PMR_NORMAL = 3'b001,
        PMR_IDLE = 3'b010,
        PMR_SLEEP = 3'b011,
        PMR_OSC_START = 3'b100
    } pmr_mode_t;

endpackage : pmr_pkg

`default_nettype wire

// file: rtl/pmr_counter.sv
`default_nettype none

// Down counter that reports done once a loaded count has elapsed.
module pmr_counter #(
    parameter int unsigned WIDTH = 24
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Control.
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    // Status.
    output logic done
);

    logic [WIDTH-1:0] cnt_reg;

    // Load restarts the wait; the count then runs down to zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= '0;
        end
        else if (clk_en)
        begin
            if (load)
            begin
                cnt_reg <= load_val;
            end
            else if (cnt_reg != '0)
            begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    // Done while no wait is pending.
    assign done = (cnt_reg == '0) && !load;

endmodule : pmr_counter

`default_nettype wire

// file: rtl/pmr_supply_mon.sv
`default_nettype none

// Supply-threshold reset with hysteresis, driven by comparator levels.
module pmr_supply_mon #(
    parameter int unsigned POR_CNT = pmr_pkg::POR_CYCLES
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Comparator levels.
    input wire logic supply_above_hi,
    input wire logic supply_above_lo,
    // Result.
    output logic por_active
);
    import pmr_pkg::*;

    logic armed_reg;
    logic load;
    logic done;

    // Arm when the high threshold is crossed; disarm only below the low one.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            armed_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!supply_above_lo)
            begin
                armed_reg <= 1'b0;
            end
            else if (supply_above_hi)
            begin
                armed_reg <= 1'b1;
            end
        end
    end

    // Release timer restarts each time the supply is not yet armed.
    assign load = !armed_reg;

    pmr_counter #(
        .WIDTH(24)
    ) u_por_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .load(load),
        .load_val(24'(POR_CNT)),
        .done(done)
    );

    // Reset holds until armed and the release timer has run out.
    assign por_active = !(armed_reg && done);

endmodule : pmr_supply_mon

`default_nettype wire

// file: rtl/pmr_top.sv
// The implementer's own choices: register access over APB and the address map.
`default_nettype none

// Power mode and reset control with APB register access.
module pmr_top #(
    parameter int unsigned POR_CNT = pmr_pkg::POR_CYCLES,
    parameter int unsigned LOCK_CNT = pmr_pkg::LOCK_CYCLES,
    parameter int unsigned OSC_CNT = pmr_pkg::OSC_CYCLES
) (
    // Clock, reset and enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Supply comparators and external reset pin.
    input wire logic supply_above_hi,
    input wire logic supply_above_lo,
    input wire logic ext_reset,
    // Wake sources, already gated by their own interrupt enables.
    input wire logic any_irq_enabled,
    input wire logic interval_wake_timer_irq,
    input wire logic serial_irq,
    input wire logic external_interrupt_zero_irq,
    // Clock gating and pin control.
    output logic core_reset,
    output logic core_clk_en,
    output logic periph_clk_en,
    output logic pll_en,
    output logic osc_en,
    output logic timer_clk_en,
    output logic hold_pins,
    output logic dac_hiz,
    output logic strobe_force,
    output logic strobe_level,
    output logic resume_after_sleep
);
    import pmr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    pmr_mode_t mode_reg;
    pmr_mode_t mode_next;
    logic [7:0] power_control_reg;
    logic [7:0] pll_control_reg;
    logic por_active;
    logic sys_rst;
    logic lock_load;
    logic lock_done;
    logic osc_load;
    logic osc_done;
    logic pll_locked;
    logic wr_acc;
    logic rd_acc;
    logic sleep_wake;
    logic [31:0] rd_next;

    ////////////////////////////////////////////////////////////////////////
    // Reset sources.

    pmr_supply_mon #(
        .POR_CNT(POR_CNT)
    ) u_supply (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .supply_above_hi(supply_above_hi),
        .supply_above_lo(supply_above_lo),
        .por_active(por_active)
    );

    // Supply reset or the external pin resets the mode register and both control registers.
    assign sys_rst = por_active || ext_reset;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.

    // Access phase; the slave answers with zero wait states.
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;

    ////////////////////////////////////////////////////////////////////////
    // Wake decode.

    // Power-down wake sources, each behind its own enable.
    assign sleep_wake =
        (interval_wake_timer_irq && power_control_reg[TIMER_EN_BIT]
            && !pll_control_reg[OSC_OFF_BIT])
        || (serial_irq && power_control_reg[SER_WAKE_BIT])
        || (external_interrupt_zero_irq && power_control_reg[EXT0_WAKE_BIT]);

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencing.

    // Next mode from request bits, wake events and oscillator startup.
    always_comb
    begin
        mode_next = mode_reg;
        unique case (mode_reg)
            PMR_RESET:
            begin
                mode_next = PMR_NORMAL;
            end
            PMR_NORMAL:
            begin
                if (power_control_reg[SLEEP_BIT])
                begin
                    mode_next = PMR_SLEEP;
                end
                else if (power_control_reg[IDLE_BIT])
                begin
                    mode_next = PMR_IDLE;
                end
            end
            PMR_IDLE:
            begin
                if (any_irq_enabled)
                begin
                    mode_next = PMR_NORMAL;
                end
            end
            PMR_SLEEP:
            begin
                if (sleep_wake)
                begin
                    mode_next = pll_control_reg[OSC_OFF_BIT] ? PMR_OSC_START : PMR_NORMAL;
                end
            end
            PMR_OSC_START:
            begin
                if (osc_done)
                begin
                    mode_next = PMR_NORMAL;
                end
            end
            default:
            begin
                mode_next = PMR_RESET;
            end
        endcase
    end

    // Mode register; a reset always lands in the reset mode first.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg <= PMR_RESET;
        end
        else if (clk_en)
        begin
            if (sys_rst)
            begin
                mode_reg <= PMR_RESET;
            end
            else
            begin
                mode_reg <= mode_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers.

    // Power control: request bits self-clear when the mode is left.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_control_reg <= PWR_CTRL_RST;
        end
        else if (clk_en)
        begin
            if (sys_rst)
            begin
                power_control_reg <= PWR_CTRL_RST;
            end
            else if (wr_acc && paddr == PWR_CTRL_ADDR)
            begin
                power_control_reg <= pwdata[7:0];
            end
            else if ((mode_reg == PMR_IDLE || mode_reg == PMR_SLEEP)
                && mode_next != mode_reg)
            begin
                power_control_reg[IDLE_BIT] <= 1'b0;
                power_control_reg[SLEEP_BIT] <= 1'b0;
            end
        end
    end

    // PLL control: only the oscillator-off bit is writable.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pll_control_reg <= PLL_CTRL_RST;
        end
        else if (clk_en)
        begin
            if (sys_rst)
            begin
                pll_control_reg <= PLL_CTRL_RST;
            end
            else if (wr_acc && paddr == PLL_CTRL_ADDR)
            begin
                pll_control_reg[OSC_OFF_BIT] <= pwdata[OSC_OFF_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PLL lock and oscillator startup timing.

    // Lock wait restarts whenever the PLL is off or the oscillator is starting.
    assign lock_load = (mode_reg == PMR_SLEEP) || (mode_reg == PMR_OSC_START)
        || (mode_reg == PMR_RESET);
    assign osc_load = (mode_reg == PMR_SLEEP);

    pmr_counter #(
        .WIDTH(24)
    ) u_lock_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .load(lock_load),
        .load_val(24'(LOCK_CNT)),
        .done(lock_done)
    );

    pmr_counter #(
        .WIDTH(24)
    ) u_osc_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .load(osc_load),
        .load_val(24'(OSC_CNT)),
        .done(osc_done)
    );

    assign pll_locked = lock_done && !lock_load;

    ////////////////////////////////////////////////////////////////////////
    // Read data.

    // Read mux; unmapped addresses read zero without error.
    always_comb
    begin
        rd_next = 32'h0000_0000;
        unique case (paddr)
            PWR_CTRL_ADDR:
            begin
                rd_next[7:0] = power_control_reg;
            end
            PLL_CTRL_ADDR:
            begin
                rd_next[7:0] = pll_control_reg;
                rd_next[LOCK_BIT] = pll_locked;
            end
            MODE_STAT_ADDR:
            begin
                rd_next[2:0] = mode_reg;
            end
            default:
            begin
                rd_next = 32'h0000_0000;
            end
        endcase
    end

    // Bus outputs registered; pready high so every access takes two cycles.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite)
            begin
                prdata <= rd_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock gating and pin control outputs.

    // Gating outputs registered from the next mode; core_reset from the current mode.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_reset <= 1'b1;
            core_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            pll_en <= 1'b0;
            osc_en <= 1'b1;
            timer_clk_en <= 1'b0;
            hold_pins <= 1'b0;
            dac_hiz <= 1'b0;
            strobe_force <= 1'b0;
            strobe_level <= 1'b0;
            resume_after_sleep <= 1'b0;
        end
        else if (clk_en)
        begin
            core_reset <= sys_rst || mode_reg == PMR_RESET;
            core_clk_en <= !sys_rst && mode_next != PMR_IDLE
                && mode_next != PMR_SLEEP && mode_next != PMR_OSC_START;
            periph_clk_en <= !sys_rst && mode_next != PMR_SLEEP
                && mode_next != PMR_OSC_START;
            pll_en <= mode_next != PMR_SLEEP && mode_next != PMR_OSC_START;
            osc_en <= !(mode_next == PMR_SLEEP && pll_control_reg[OSC_OFF_BIT]);
            timer_clk_en <= power_control_reg[TIMER_EN_BIT]
                && !(mode_next == PMR_SLEEP && pll_control_reg[OSC_OFF_BIT]);
            hold_pins <= mode_next == PMR_IDLE || mode_next == PMR_SLEEP;
            dac_hiz <= mode_next == PMR_SLEEP;
            strobe_force <= mode_next == PMR_IDLE || mode_next == PMR_SLEEP;
            strobe_level <= mode_next == PMR_IDLE;
            resume_after_sleep <= mode_reg == PMR_SLEEP && mode_next != PMR_SLEEP;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    a_idle_strobes_high: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !sys_rst && mode_next == PMR_IDLE) |=> (strobe_force && strobe_level))
        else $error("Strobes not high in idle.");

    a_sleep_strobes_low: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !sys_rst && mode_next == PMR_SLEEP) |=> (strobe_force && !strobe_level
            && dac_hiz))
        else $error("Strobes or DAC wrong in power-down.");

    a_idle_core_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && mode_next == PMR_IDLE) |=> (!core_clk_en && pll_en && osc_en))
        else $error("Idle clocking wrong.");

    a_sleep_pll_off: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && mode_next == PMR_SLEEP) |=> (!pll_en && !core_clk_en
            && osc_en == !$past(pll_control_reg[OSC_OFF_BIT])))
        else $error("Power-down clocking wrong.");

    a_idle_wake_irq: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && mode_reg == PMR_IDLE && any_irq_enabled && !sys_rst)
            |=> mode_reg == PMR_NORMAL)
        else $error("Idle did not end on interrupt.");

    a_ser_wake: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !sys_rst && mode_reg == PMR_SLEEP && serial_irq
            && power_control_reg[SER_WAKE_BIT]) |=> mode_reg != PMR_SLEEP)
        else $error("Serial wake missed.");

    a_ext0_wake: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !sys_rst && mode_reg == PMR_SLEEP && external_interrupt_zero_irq
            && power_control_reg[EXT0_WAKE_BIT]) |=> mode_reg != PMR_SLEEP)
        else $error("External interrupt wake missed.");

    a_ext_reset_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && ext_reset) |=> (mode_reg == PMR_RESET && power_control_reg == 8'h00))
        else $error("External reset did not reset mode.");

    a_lock_after_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && mode_reg == PMR_SLEEP) |=> !pll_locked)
        else $error("Lock reported during power-down.");

endmodule : pmr_top

`default_nettype wire

// file: dv/pmr_top_tb.sv
`default_nettype none

// Self-checking bench for the power mode and reset control block.
module pmr_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pmr_pkg::*;

    // Shortened counts so the long timers finish quickly.
    localparam int unsigned POR_T = 20;
    localparam int unsigned LOCK_T = 10;
    localparam int unsigned OSC_T = 15;

    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] m; logic [31:0] e;} pmr_row_t;
    typedef struct {logic [7:0] pwr; logic [7:0] pll; int src; logic wake;} pmr_wake_t;

    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic supply_above_hi, supply_above_lo, ext_reset, any_irq_enabled;
    logic [2:0] wake_irq;
    logic core_reset, core_clk_en, periph_clk_en, pll_en, osc_en, timer_clk_en;
    logic hold_pins, dac_hiz, strobe_force, strobe_level, resume_after_sleep;
    int failures = 0;
    int checks = 0;
    pmr_row_t rows [6];
    pmr_wake_t wk [7];

    ////////////////////////////////////////////////////////////////////////////////
    pmr_top #(.POR_CNT(POR_T), .LOCK_CNT(LOCK_T), .OSC_CNT(OSC_T)) dut_u (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_above_hi(supply_above_hi), .supply_above_lo(supply_above_lo),
        .ext_reset(ext_reset), .any_irq_enabled(any_irq_enabled),
        .interval_wake_timer_irq(wake_irq[0]), .serial_irq(wake_irq[1]),
        .external_interrupt_zero_irq(wake_irq[2]),
        .core_reset(core_reset), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
        .pll_en(pll_en), .osc_en(osc_en), .timer_clk_en(timer_clk_en), .hold_pins(hold_pins),
        .dac_hiz(dac_hiz), .strobe_force(strobe_force), .strobe_level(strobe_level),
        .resume_after_sleep(resume_after_sleep)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Compares a seen value with the expected one and counts both outcomes.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        chk(pslverr, 1'b0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Waits a bounded number of cycles for a chosen output to reach a level.
    task automatic wait_sig(input int sel, input logic v, input int lim);
        logic s;
        int n;
        s = ~v;
        for (n = 0; n < lim; n++)
        begin
            @(posedge pclk);
            #1;
            case (sel)
                0: s = core_reset;
                1: s = core_clk_en;
                default: s = resume_after_sleep;
            endcase
            if (s === v)
                break;
        end
        chk(s, v);
    endtask : wait_sig

    // Checks every gating and pin output while power-down is held.
    task automatic sleep_outs(input logic osc, input logic interval_wake_timer);
        chk(core_clk_en, 1'b0);
        chk(pll_en, 1'b0);
        chk(osc_en, osc);
        chk(periph_clk_en, 1'b0);
        chk(timer_clk_en, interval_wake_timer & osc);
        chk(hold_pins, 1'b1);
        chk(dac_hiz, 1'b1);
        chk({strobe_force, strobe_level}, 2'b10);
    endtask : sleep_outs

    // Prints the counts and the verdict, then ends the run.
    task print_verdict;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////////
    // Clock of 100 ns period.
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Watchdog that cuts a hang short.
    initial
    begin
        #(100 * 5000);
        failures++;
        print_verdict();
    end

    // Main sequence.
    initial
    begin
        rows = '{'{PWR_CTRL_ADDR, 32'h0000_001C, 32'h0000_00FF, 32'h0000_001C},
                 '{PWR_CTRL_ADDR, 32'h0000_0000, 32'h0000_00FF, 32'h0000_0000},
                 '{PLL_CTRL_ADDR, 32'h0000_0008, 32'h0000_00BF, 32'h0000_0008},
                 '{PLL_CTRL_ADDR, 32'h0000_0000, 32'h0000_00BF, 32'h0000_0000},
                 '{MODE_STAT_ADDR, 32'h0000_00FF, 32'h0000_0007, 32'h0000_0001},
                 '{8'h0C, 32'h0000_00FF, 32'hFFFF_FFFF, 32'h0000_0000}};
        wk = '{'{8'h12, 8'h00, 0, 1'b1}, '{8'h02, 8'h00, 0, 1'b0}, '{8'h12, 8'h08, 0, 1'b0},
               '{8'h06, 8'h00, 1, 1'b1}, '{8'h02, 8'h00, 1, 1'b0},
               '{8'h0A, 8'h08, 2, 1'b1}, '{8'h02, 8'h00, 2, 1'b0}};
        {presetn, psel, penable, pwrite, ext_reset, any_irq_enabled} = '0;
        {clk_en, supply_above_hi, supply_above_lo} = 3'b111;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        wake_irq = 3'b000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
        #1;
        chk(core_reset, 1'b1);
        wait_sig(0, 1'b0, POR_T + 10);
        $display("test power_on done");
        // Ordinary register rows: write then read back.
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].w, q);
            apb(1'b0, rows[i].a, 32'h0000_0000, q);
            chk(q & rows[i].m, rows[i].e);
        end
        $display("test registers done");
        // Idle entry and wake by any enabled interrupt.
        apb(1'b1, PWR_CTRL_ADDR, 32'h0000_0001, q);
        repeat (3) @(posedge pclk);
        #1;
        chk({core_clk_en, periph_clk_en, osc_en, pll_en}, 4'b0111);
        chk({strobe_force, strobe_level, dac_hiz, hold_pins}, 4'b1101);
        apb(1'b0, MODE_STAT_ADDR, 32'h0000_0000, q);
        chk(q & 32'h0000_0007, 32'h0000_0002);
        any_irq_enabled <= 1'b1;
        wait_sig(1, 1'b1, 5);
        any_irq_enabled <= 1'b0;
        apb(1'b0, PWR_CTRL_ADDR, 32'h0000_0000, q);
        chk(q & 32'h0000_0003, 32'h0000_0000);
        $display("test idle done");
        // Power-down with each wake source, enabled and not.
        foreach (wk[i])
        begin
            apb(1'b1, PLL_CTRL_ADDR, {24'h0, wk[i].pll}, q);
            apb(1'b1, PWR_CTRL_ADDR, {24'h0, wk[i].pwr}, q);
            repeat (3) @(posedge pclk);
            #1;
            sleep_outs(!wk[i].pll[OSC_OFF_BIT], wk[i].pwr[TIMER_EN_BIT]);
            apb(1'b0, PLL_CTRL_ADDR, 32'h0000_0000, q);
            chk(q & 32'h0000_0040, 32'h0000_0000);
            @(posedge pclk);
            wake_irq[wk[i].src] <= 1'b1;
            any_irq_enabled <= !wk[i].wake;
            if (wk[i].wake)
            begin
                wait_sig(2, 1'b1, OSC_T + LOCK_T + 20);
                wake_irq <= 3'b000;
                wait_sig(1, 1'b1, OSC_T + 5);
                apb(1'b0, PLL_CTRL_ADDR, 32'h0000_0000, q);
                chk(q & 32'h0000_0040, 32'h0000_0000);
                for (int n = 0; n < 40 && q[LOCK_BIT] !== 1'b1; n++)
                    apb(1'b0, PLL_CTRL_ADDR, 32'h0000_0000, q);
                chk(q[LOCK_BIT], 1'b1);
            end
            else
            begin
                repeat (8) @(posedge pclk);
                #1;
                chk({core_clk_en, resume_after_sleep}, 2'b00);
                @(posedge pclk);
                wake_irq <= 3'b000;
                any_irq_enabled <= 1'b0;
                ext_reset <= 1'b1;
                repeat (2) @(posedge pclk);
                ext_reset <= 1'b0;
                wait_sig(1, 1'b1, 10);
                apb(1'b0, PLL_CTRL_ADDR, 32'h0000_0000, q);
                chk(q & 32'h0000_00BF, 32'h0000_0000);
            end
            apb(1'b0, PWR_CTRL_ADDR, 32'h0000_0000, q);
            chk(q & 32'h0000_0003, 32'h0000_0000);
        end
        $display("test power_down done");
        // Supply falling through the upper level, then below the lower one.
        @(posedge pclk);
        supply_above_hi <= 1'b0;
        repeat (10) @(posedge pclk);
        #1;
        chk(core_reset, 1'b0);
        supply_above_lo <= 1'b0;
        wait_sig(0, 1'b1, 5);
        supply_above_lo <= 1'b1;
        repeat (POR_T + 5) @(posedge pclk);
        #1;
        chk(core_reset, 1'b1);
        supply_above_hi <= 1'b1;
        repeat (10) @(posedge pclk);
        #1;
        chk(core_reset, 1'b1);
        wait_sig(0, 1'b0, POR_T + 5);
        $display("test supply done");
        // Reset in the middle of idle clears the request bits.
        apb(1'b1, PWR_CTRL_ADDR, 32'h0000_0001, q);
        repeat (3) @(posedge pclk);
        #1;
        chk(strobe_level, 1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wait_sig(0, 1'b0, POR_T + 10);
        apb(1'b0, PWR_CTRL_ADDR, 32'h0000_0000, q);
        chk(q & 32'h0000_00FF, 32'h0000_0000);
        apb(1'b0, MODE_STAT_ADDR, 32'h0000_0000, q);
        chk(q & 32'h0000_0007, 32'h0000_0001);
        $display("test reset_in_idle done");
        print_verdict();
    end

endmodule : pmr_top_tb

`default_nettype wire
